/* include/uesb_consts.vh */
`ifndef UESB_CONSTS_VH
`define UESB_CONSTS_VH

// command codes; select is the physical endpoint number itself
`define UESB_CMD_SET_ST 8'h40
`define UESB_CMD_BUF 8'hF0
`define UESB_CMD_CLR 8'hF2
`define UESB_CMD_VAL 8'hFA

// select status byte bit positions
`define UESB_SEL_FULL 0
`define UESB_SEL_STALL 1
`define UESB_SEL_SETUP 2
`define UESB_SEL_OVW 3
`define UESB_SEL_NAK 4

// set status byte bit positions
`define UESB_SET_STALL 0
`define UESB_SET_DIS 5
`define UESB_SET_RFB 6
`define UESB_SET_B7 7

// buffer header byte 0 bit positions
`define UESB_HDR_OK 7
`define UESB_HDR_SETUP 6

// clear buffer result bit
`define UESB_CLR_OVW 0

// token pids from the serial engine
`define UESB_PID_OUT 2'h0
`define UESB_PID_IN 2'h1
`define UESB_PID_SETUP 2'h2

// handshake codes towards the serial engine
`define UESB_HS_ACK 2'h0
`define UESB_HS_NAK 2'h1
`define UESB_HS_STALL 2'h2

// command interface modes
`define UESB_MD_NONE 3'h0
`define UESB_MD_SEL 3'h1
`define UESB_MD_SET 3'h2
`define UESB_MD_BUF 3'h3
`define UESB_MD_CLR 3'h4

// receive decisions taken at the token
`define UESB_RX_IGN 2'h0
`define UESB_RX_ACC 2'h1
`define UESB_RX_NAK 2'h2
`define UESB_RX_STL 2'h3

// number of physical control endpoints
`define UESB_NUM_CTRL 2

`endif

/* logic/uesb_mem.v */
// simple dual port byte store, registered read data
module uesb_mem #(
    parameter DW = 8,
    parameter AW = 7
) (
    input wire clk_sys_i, // system clock
    input wire rst_n_i, // sync reset, active low
    input wire wr_en_i, // write strobe
    input wire [AW-1:0] wr_addr_i, // write address
    input wire [DW-1:0] wr_dat_i, // write data
    input wire rd_en_i, // read strobe
    input wire [AW-1:0] rd_addr_i, // read address
    output reg [DW-1:0] rd_dat_o // read data, one cycle after strobe
);
    reg [DW-1:0] mem_r [0:(1<<AW)-1];

    // array has no reset so it can map to block ram
    always @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_dat_i;
        end
    end

    // read port holds its last value between strobes
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rd_dat_o <= {DW{1'b0}};
        end else if (rd_en_i) begin
            rd_dat_o <= mem_r[rd_addr_i];
        end
    end
endmodule // uesb_mem

/* logic/uesb_ep_core.v */
// Behaviour
// - select status byte: full b0, stall b1, setup b2, overwritten b3, sent-nak b4; reset 0
// - clear buffer empties an out buffer only when it was not overwritten
// - validate buffer marks an in buffer full, except the control in buffer while its out pair is overwritten
// - setup bit follows every stored received packet (toggle retries are acked but not stored), 1 when it was setup
// - overwritten set when setup replaces a full buffer, cleared by select
// - nak an out packet to a full buffer and an in token to an empty one
// - sent-nak flag set on each nak of a control endpoint while interrupt-on-nak is enabled
// - sent-nak cleared by ack after out or host ack after in; control only
// - set status byte: stall b0, disable b5, rate feedback b6, unmask/cond stall b7
// - disable bit disables a non-control endpoint; bus reset clears all disable bits
// - rate feedback 0 gives toggle mode, 1 gives rate feedback mode on non-control endpoints only
// - unmasked endpoint raises an interrupt on any of its events
// - conditional stall stalls both endpoint zero directions unless setup is set
// - setup token unstalls a stalled control endpoint; firmware restalls if wanted
// - unstall or stall bit written 0 flushes buffer and restarts at data0
// - stalling through set status also reinitialises the endpoint
// - buffer read byte 0: b7 received ok, b6 setup, b0 zero
// - buffer read byte 1 is the byte count, data follows from byte 2
// - clear buffer result byte reports overwritten in bit 0, reset 0
// - a buffer whose overwritten flag is set cannot be cleared
// - select code is the endpoint number, set status code is 40h plus it
`include "uesb_consts.vh"

module uesb_ep_core #(
    parameter LW = 1, // logical endpoint index width
    parameter BAW = 6 // buffer address width, 64 byte packets
) (
    input wire clk_sys_i, // system clock, 125 MHz
    input wire rst_n_i, // sync reset, active low
    input wire cmd_wr_i, // command strobe
    input wire [7:0] cmd_i, // command code
    input wire dat_wr_i, // data write strobe
    input wire [7:0] dat_i, // data write byte
    input wire dat_rd_i, // data read strobe
    output reg [7:0] dat_o, // data read byte
    output reg dat_vld_o, // data read byte valid, pulse
    output reg ep_int_o, // endpoint interrupt, level
    input wire int_on_nak_i, // interrupt-on-nak feature enable
    input wire usb_bus_rst_i, // usb bus reset seen, pulse
    input wire usb_tok_vld_i, // token received, pulse
    input wire [1:0] usb_tok_pid_i, // token kind
    input wire [LW-1:0] usb_tok_ep_i, // token logical endpoint
    input wire usb_rx_vld_i, // received data byte strobe
    input wire [7:0] usb_rx_dat_i, // received data byte
    input wire usb_rx_end_i, // end of data packet, pulse
    input wire usb_rx_ok_i, // packet crc good, with end
    input wire usb_rx_data1_i, // packet pid was data1, with end
    input wire usb_tx_rd_i, // fetch next in byte
    input wire usb_ack_i, // host ack after in packet, pulse
    output reg usb_hs_vld_o, // handshake request, pulse
    output reg [1:0] usb_hs_o, // handshake kind
    output reg usb_tx_start_o, // send in packet, pulse
    output reg [BAW:0] usb_tx_len_o, // in packet byte count
    output reg usb_tx_data1_o, // in packet uses data1
    output wire [7:0] usb_tx_dat_o // in byte, one cycle after fetch
);
    localparam EW = LW + 1;
    localparam NEP = 2 << LW;
    localparam CW = BAW + 1;
    localparam MAW = LW + BAW;
    localparam [7:0] NEP8 = NEP;
    localparam [7:0] ZERO8 = 8'h00;
    localparam [7:0] ONE8 = 8'h01;
    localparam [7:0] TWO8 = 8'h02;
    localparam [CW-1:0] MAXC = 1 << BAW;

    wire [NEP-1:0] full_v, stall_v, stl_eff_v, setup_v, ovw_v, nak_v;
    wire [NEP-1:0] dis_v, b7_v, tog_v, rxok_v, ipend_v;
    wire [NEP*CW-1:0] cnt_v;
    wire [7:0] out_q;

    reg [2:0] mode_r;
    reg [EW-1:0] sel_ep_r;
    reg [EW-1:0] st_ep_r;
    reg [7:0] ptr_r;
    reg [7:0] reply_r;
    reg [7:0] rd_byte_r;
    reg rd_mem_r;
    reg rd_pend_r;
    reg [1:0] rx_mode_r;
    reg rx_setup_r;
    reg [EW-1:0] rx_ep_r;
    reg [CW-1:0] rx_cnt_r;
    reg [EW-1:0] tx_ep_r;
    reg [BAW-1:0] tx_idx_r;
    reg [EW-1:0] nak_ep_r;
    reg nak_ev_r;

    // command decode; select code equals the endpoint number
    wire [7:0] st_off = cmd_i - `UESB_CMD_SET_ST;
    wire cmd_sel = cmd_wr_i & (cmd_i < NEP8);
    wire cmd_set = cmd_wr_i & (st_off < NEP8);
    wire cmd_buf = cmd_wr_i & (cmd_i == `UESB_CMD_BUF);
    wire cmd_clr = cmd_wr_i & (cmd_i == `UESB_CMD_CLR);
    wire cmd_val = cmd_wr_i & (cmd_i == `UESB_CMD_VAL);
    wire set_wr = dat_wr_i & (mode_r == `UESB_MD_SET);
    wire sel_in = sel_ep_r[0];
    wire [LW-1:0] sel_log = sel_ep_r[EW-1:1];
    wire [CW-1:0] sel_cnt = cnt_v[sel_ep_r*CW +: CW];
    wire buf_rd = dat_rd_i & (mode_r == `UESB_MD_BUF) & ~sel_in;
    wire buf_wr = dat_wr_i & (mode_r == `UESB_MD_BUF) & sel_in;
    wire [7:0] ptr_d = ptr_r - TWO8;

    // usb token side; out and setup target the even endpoint, in the odd one
    wire [EW-1:0] tok_out_ep = {usb_tok_ep_i, 1'b0};
    wire [EW-1:0] tok_in_ep = {usb_tok_ep_i, 1'b1};
    wire tok_setup = usb_tok_vld_i & (usb_tok_pid_i == `UESB_PID_SETUP);
    wire tok_out = usb_tok_vld_i & (usb_tok_pid_i == `UESB_PID_OUT);
    wire tok_in = usb_tok_vld_i & (usb_tok_pid_i == `UESB_PID_IN);
    wire in_ok = ~dis_v[tok_in_ep] & ~stl_eff_v[tok_in_ep] & full_v[tok_in_ep];
    wire rx_fin = usb_rx_end_i & usb_rx_ok_i & (rx_mode_r != `UESB_RX_IGN);
    // a data pid that does not match the toggle is a retry: acked, not stored
    wire rx_seq = rx_setup_r | (usb_rx_data1_i == tog_v[rx_ep_r]);
    wire rx_done = rx_fin & (rx_mode_r == `UESB_RX_ACC) & rx_seq;
    wire rx_ack = rx_fin & (rx_mode_r == `UESB_RX_ACC);
    wire mem_wr = usb_rx_vld_i & (rx_mode_r == `UESB_RX_ACC) & (rx_cnt_r < MAXC);

    // per endpoint status and control state
    genvar e;
    generate
        for (e = 0; e < NEP; e = e + 1) begin : g_ep
            localparam [0:0] CTRL = (e < `UESB_NUM_CTRL);
            localparam [EW-1:0] ID = e;
            reg full_r, stall_r, setup_r, ovw_r, nak_r, dis_r, rfb_r, b7_r;
            reg tog_r, rxok_r, ipend_r;
            reg [CW-1:0] cnt_r;
            wire sel = cmd_sel & (cmd_i[EW-1:0] == ID);
            wire setst = set_wr & (st_ep_r == ID);
            wire su_unst = tok_setup & CTRL & stall_r;
            wire reinit = setst | su_unst;
            wire clr = cmd_clr & (sel_ep_r == ID);
            wire pair_ovw = CTRL & ovw_v[ID ^ ONE8[EW-1:0]];
            wire val = cmd_val & (sel_ep_r == ID) & ID[0] & ~pair_ovw;
            wire rxd = rx_done & (rx_ep_r == ID);
            wire ack_out = rx_ack & (rx_ep_r == ID);
            wire ack_in = usb_ack_i & (tx_ep_r == ID);
            wire nak_ev = nak_ev_r & (nak_ep_r == ID);
            wire tx_go = tok_in & (tok_in_ep == ID) & in_ok;
            wire ld_cnt = buf_wr & (sel_ep_r == ID) & (ptr_r == ONE8);
            // control endpoints always interrupt, others only when unmasked
            wire ien = CTRL ? 1'b1 : b7_r;
            wire cstall = CTRL & (b7_v[0] | b7_v[1]) & ~setup_v[0];
            assign full_v[e] = full_r;
            assign stall_v[e] = stall_r;
            assign stl_eff_v[e] = stall_r | cstall;
            assign setup_v[e] = setup_r;
            assign ovw_v[e] = ovw_r;
            assign nak_v[e] = nak_r;
            assign dis_v[e] = dis_r;
            assign b7_v[e] = b7_r;
            assign tog_v[e] = tog_r;
            assign rxok_v[e] = rxok_r;
            assign ipend_v[e] = ipend_r;
            assign cnt_v[e*CW +: CW] = cnt_r;

            // later assignments win, so hardware sets override clears
            always @(posedge clk_sys_i) begin
                if (!rst_n_i) begin
                    full_r <= 1'b0;
                    stall_r <= 1'b0;
                    setup_r <= 1'b0;
                    ovw_r <= 1'b0;
                    nak_r <= 1'b0;
                    dis_r <= 1'b0;
                    rfb_r <= 1'b0;
                    b7_r <= 1'b0;
                    tog_r <= 1'b0;
                    rxok_r <= 1'b0;
                    ipend_r <= 1'b0;
                    cnt_r <= {CW{1'b0}};
                end else begin
                    if (setst) begin
                        stall_r <= dat_i[`UESB_SET_STALL];
                        dis_r <= ~CTRL & dat_i[`UESB_SET_DIS];
                        rfb_r <= ~CTRL & dat_i[`UESB_SET_RFB];
                        b7_r <= dat_i[`UESB_SET_B7];
                    end
                    if (su_unst) begin
                        stall_r <= 1'b0;
                    end
                    if (usb_bus_rst_i) begin
                        dis_r <= 1'b0;
                    end
                    // flush and restart the data sequence at data0
                    if (reinit) begin
                        full_r <= 1'b0;
                        tog_r <= 1'b0;
                        rxok_r <= 1'b0;
                        cnt_r <= {CW{1'b0}};
                    end
                    if (ack_in) begin
                        full_r <= 1'b0;
                        if (!rfb_r) begin
                            tog_r <= ~tog_r;
                        end
                    end
                    if (clr & ~ovw_r) begin
                        full_r <= 1'b0;
                    end
                    if (val) begin
                        full_r <= 1'b1;
                    end
                    if (ld_cnt) begin
                        cnt_r <= dat_i[CW-1:0];
                    end
                    if (rxd) begin
                        full_r <= 1'b1;
                        setup_r <= rx_setup_r;
                        rxok_r <= 1'b1;
                        cnt_r <= rx_cnt_r;
                        tog_r <= rx_setup_r | ~tog_r;
                    end
                    if (tx_go & rfb_r) begin
                        tog_r <= ~tog_r;
                    end
                    if (sel) begin
                        ovw_r <= 1'b0;
                        ipend_r <= 1'b0;
                    end
                    if (rxd & rx_setup_r & full_r) begin
                        ovw_r <= 1'b1;
                    end
                    if (ack_out | ack_in) begin
                        nak_r <= 1'b0;
                    end
                    if (nak_ev & int_on_nak_i & CTRL) begin
                        nak_r <= 1'b1;
                    end
                    if (ien & (rxd | ack_in | nak_ev)) begin
                        ipend_r <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // command interface: mode, endpoint, pointer, reply
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            mode_r <= `UESB_MD_NONE;
            sel_ep_r <= {EW{1'b0}};
            st_ep_r <= {EW{1'b0}};
            ptr_r <= 8'h00;
            reply_r <= 8'h00;
        end else begin
            if (cmd_sel) begin
                mode_r <= `UESB_MD_SEL;
                sel_ep_r <= cmd_i[EW-1:0];
                ptr_r <= 8'h00;
                reply_r <= {3'b000,
                    nak_v[cmd_i[EW-1:0]],
                    ovw_v[cmd_i[EW-1:0]],
                    setup_v[cmd_i[EW-1:0]],
                    stl_eff_v[cmd_i[EW-1:0]],
                    full_v[cmd_i[EW-1:0]]};
            end else if (cmd_set) begin
                mode_r <= `UESB_MD_SET;
                st_ep_r <= st_off[EW-1:0];
            end else if (cmd_buf) begin
                mode_r <= `UESB_MD_BUF;
            end else if (cmd_clr) begin
                mode_r <= `UESB_MD_CLR;
                reply_r <= {7'h00, ovw_v[sel_ep_r]};
            end else if (cmd_wr_i) begin
                mode_r <= `UESB_MD_NONE;
            end else if (set_wr) begin
                mode_r <= `UESB_MD_NONE;
            end else if ((buf_rd | buf_wr) & (ptr_r != 8'hFF)) begin
                ptr_r <= ptr_r + ONE8; // pointer survives other commands
            end
        end
    end

    // read pipeline: strobe, then byte pick, then the output flop
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rd_pend_r <= 1'b0;
            rd_mem_r <= 1'b0;
            rd_byte_r <= 8'h00;
            dat_o <= 8'h00;
            dat_vld_o <= 1'b0;
        end else begin
            rd_pend_r <= dat_rd_i;
            rd_mem_r <= buf_rd & (ptr_r >= TWO8);
            if (buf_rd & (ptr_r == ZERO8)) begin
                rd_byte_r <= {rxok_v[sel_ep_r], setup_v[sel_ep_r], 6'h00};
            end else if (buf_rd) begin
                rd_byte_r <= {{(8-CW){1'b0}}, sel_cnt};
            end else if ((mode_r == `UESB_MD_SEL) | (mode_r == `UESB_MD_CLR)) begin
                rd_byte_r <= reply_r;
            end else begin
                rd_byte_r <= 8'h00;
            end
            dat_vld_o <= rd_pend_r;
            dat_o <= rd_mem_r ? out_q : rd_byte_r;
        end
    end

    // tokens, handshakes and in packet launch
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rx_mode_r <= `UESB_RX_IGN;
            rx_setup_r <= 1'b0;
            rx_ep_r <= {EW{1'b0}};
            rx_cnt_r <= {CW{1'b0}};
            tx_ep_r <= {EW{1'b0}};
            tx_idx_r <= {BAW{1'b0}};
            nak_ev_r <= 1'b0;
            nak_ep_r <= {EW{1'b0}};
            usb_hs_vld_o <= 1'b0;
            usb_hs_o <= `UESB_HS_ACK;
            usb_tx_start_o <= 1'b0;
            usb_tx_len_o <= {CW{1'b0}};
            usb_tx_data1_o <= 1'b0;
            ep_int_o <= 1'b0;
        end else begin
            usb_hs_vld_o <= 1'b0;
            usb_tx_start_o <= 1'b0;
            nak_ev_r <= 1'b0;
            ep_int_o <= |ipend_v;
            if (tok_setup | tok_out) begin
                rx_ep_r <= tok_out_ep;
                rx_setup_r <= tok_setup;
                rx_cnt_r <= {CW{1'b0}};
                if (dis_v[tok_out_ep]) begin
                    rx_mode_r <= `UESB_RX_IGN;
                end else if (tok_setup) begin
                    rx_mode_r <= `UESB_RX_ACC;
                end else if (stl_eff_v[tok_out_ep]) begin
                    rx_mode_r <= `UESB_RX_STL;
                end else if (full_v[tok_out_ep]) begin
                    rx_mode_r <= `UESB_RX_NAK;
                end else begin
                    rx_mode_r <= `UESB_RX_ACC;
                end
            end else if (usb_rx_end_i) begin
                rx_mode_r <= `UESB_RX_IGN;
            end else if (mem_wr) begin
                rx_cnt_r <= rx_cnt_r + ONE8[CW-1:0];
            end
            if (rx_fin) begin
                usb_hs_vld_o <= 1'b1;
                usb_hs_o <= (rx_mode_r == `UESB_RX_ACC) ? `UESB_HS_ACK :
                    (rx_mode_r == `UESB_RX_NAK) ? `UESB_HS_NAK : `UESB_HS_STALL;
                nak_ev_r <= (rx_mode_r == `UESB_RX_NAK);
                nak_ep_r <= rx_ep_r;
            end
            if (tok_in & ~dis_v[tok_in_ep]) begin
                tx_ep_r <= tok_in_ep;
                tx_idx_r <= {BAW{1'b0}};
                if (stl_eff_v[tok_in_ep]) begin
                    usb_hs_vld_o <= 1'b1;
                    usb_hs_o <= `UESB_HS_STALL;
                end else if (!full_v[tok_in_ep]) begin
                    usb_hs_vld_o <= 1'b1;
                    usb_hs_o <= `UESB_HS_NAK;
                    nak_ev_r <= 1'b1;
                    nak_ep_r <= tok_in_ep;
                end else begin
                    usb_tx_start_o <= 1'b1;
                    usb_tx_len_o <= cnt_v[tok_in_ep*CW +: CW];
                    usb_tx_data1_o <= tog_v[tok_in_ep];
                end
            end else if (usb_tx_rd_i) begin
                tx_idx_r <= tx_idx_r + ONE8[BAW-1:0];
            end
        end
    end

    // out buffers: usb side writes, firmware reads
    uesb_mem #(.DW(8), .AW(MAW)) u_out_mem (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(mem_wr),
        .wr_addr_i({rx_ep_r[EW-1:1], rx_cnt_r[BAW-1:0]}),
        .wr_dat_i(usb_rx_dat_i),
        .rd_en_i(buf_rd),
        .rd_addr_i({sel_log, ptr_d[BAW-1:0]}),
        .rd_dat_o(out_q)
    );

    // in buffers: firmware writes from byte 2, usb side reads
    uesb_mem #(.DW(8), .AW(MAW)) u_in_mem (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(buf_wr & (ptr_r >= TWO8) & (ptr_r < MAXC + TWO8)),
        .wr_addr_i({sel_log, ptr_d[BAW-1:0]}),
        .wr_dat_i(dat_i),
        .rd_en_i(usb_tx_rd_i),
        .rd_addr_i({tx_ep_r[EW-1:1], tx_idx_r}),
        .rd_dat_o(usb_tx_dat_o)
    );
endmodule // uesb_ep_core

/* bench/uesb_ep_core_checker.sv */
`include "uesb_consts.vh"

module uesb_ep_core_checker #(
    parameter LW = 1,
    parameter BAW = 6
) (
    input wire clk_sys_i, // clock
    input wire rst_n_i, // reset, low
    input wire cmd_wr_i, // command strobe
    input wire [7:0] cmd_i, // command code
    input wire dat_rd_i, // read strobe
    input wire [7:0] dat_o, // read byte
    input wire dat_vld_o, // read valid
    input wire usb_tok_vld_i, // token strobe
    input wire [1:0] usb_tok_pid_i, // token kind
    input wire usb_rx_end_i, // packet end
    input wire usb_hs_vld_o, // handshake strobe
    input wire [1:0] usb_hs_o, // handshake kind
    input wire usb_tx_start_o, // in packet start
    input wire [BAW:0] usb_tx_len_o // in byte count
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    // command side: reads answered in two cycles, spare bits low
    property p_rd_ans; dat_rd_i |-> ##2 dat_vld_o; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_vld_src; dat_vld_o |-> $past(dat_rd_i, 2); endproperty
    a_vld_src: assert property (p_vld_src) else $error("valid without read");
    property p_sel_rsv; cmd_wr_i && cmd_i < 8'h04 ##2 dat_rd_i |-> ##2 dat_o[7:5] == 3'h0; endproperty
    a_sel_rsv: assert property (p_sel_rsv) else $error("status spare bits set");
    property p_clr_rsv; cmd_wr_i && cmd_i == `UESB_CMD_CLR ##2 dat_rd_i |-> ##2 dat_o[7:1] == 7'h0;
    endproperty
    a_clr_rsv: assert property (p_clr_rsv) else $error("clear spare bits set");

    // bus side: answers only follow their causes, codes and counts in range
    property p_in_start; usb_tx_start_o |-> $past(usb_tok_vld_i) && $past(usb_tok_pid_i) == `UESB_PID_IN;
    endproperty
    a_in_start: assert property (p_in_start) else $error("in packet without token");
    property p_hs_src; usb_hs_vld_o |-> $past(usb_rx_end_i) || $past(usb_tok_vld_i); endproperty
    a_hs_src: assert property (p_hs_src) else $error("handshake without cause");
    property p_len; usb_tx_start_o |-> usb_tx_len_o <= (1 << BAW); endproperty
    a_len: assert property (p_len) else $error("in count too large");
    property p_hs_code; usb_hs_vld_o |-> usb_hs_o != 2'h3; endproperty
    a_hs_code: assert property (p_hs_code) else $error("bad handshake code");

    c_rd: cover property (dat_rd_i ##2 dat_vld_o);
    c_nak: cover property (usb_hs_vld_o && usb_hs_o == `UESB_HS_NAK);
    c_in: cover property (usb_tx_start_o);
endmodule // uesb_ep_core_checker

bind uesb_ep_core uesb_ep_core_checker #(.LW(LW), .BAW(BAW)) chk_i (.*);

/* bench/uesb_host_model.sv */
`include "uesb_consts.vh"

module uesb_host_model (
    input wire clk_sys_i, // clock
    input wire hs_vld_i, // handshake strobe
    input wire [1:0] hs_i, // handshake kind
    input wire tx_start_i, // in packet start
    input wire [6:0] tx_len_i, // in count
    input wire [7:0] tx_dat_i, // in byte
    output logic tok_vld_o = 0, // token strobe
    output logic [1:0] tok_pid_o = 2'h0, // token kind
    output logic tok_ep_o = 0, // logical endpoint
    output logic rx_vld_o = 0, // byte strobe
    output logic [7:0] rx_dat_o = 8'h00, // byte
    output logic rx_end_o = 0, // packet end
    output logic tx_rd_o = 0, // in byte fetch
    output logic ack_o = 0 // host ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] len;
    logic [7:0] b0;

    // one transaction; r is the handshake code, 3 for none, 4 for an in packet
    task automatic xfer(input [1:0] pid, input ep, input [7:0] n, output [2:0] r);
        int i;
        @(negedge clk_sys_i);
        tok_vld_o = 1;
        tok_pid_o = pid;
        tok_ep_o = ep;
        @(negedge clk_sys_i);
        tok_vld_o = 0;
        for (i = 0; i < n; i++) begin
            rx_vld_o = 1;
            rx_dat_o = 8'hC0 + i[7:0];
            @(negedge clk_sys_i);
        end
        rx_vld_o = 0;
        rx_dat_o = ~rx_dat_o; // an idle line must not keep the last byte
        if (pid != `UESB_PID_IN) begin
            rx_end_o = 1;
            @(negedge clk_sys_i);
            rx_end_o = 0;
        end
        r = 3'h3;
        for (i = 0; i < 3 && r == 3'h3; i++) begin
            if (hs_vld_i === 1'b1) r = {1'b0, hs_i};
            else if (tx_start_i === 1'b1) r = 3'h4;
            else @(negedge clk_sys_i);
        end
        if (r == 3'h4) begin
            len = tx_len_i;
            tx_rd_o = 1;
            @(negedge clk_sys_i);
            tx_rd_o = 0;
            repeat (2) @(negedge clk_sys_i);
            b0 = tx_dat_i;
            ack_o = 1;
            @(negedge clk_sys_i);
            ack_o = 0;
        end
    endtask
endmodule // uesb_host_model

/* bench/usb_endpoint_status_buffers_bench.sv */
`include "uesb_consts.vh"

module usb_endpoint_status_buffers_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 0, rst_n_i = 0, cmd_wr_i = 0, dat_wr_i = 0, dat_rd_i = 0;
    logic int_on_nak_i = 1, usb_bus_rst_i = 0, usb_rx_data1_i = 0;
    logic [7:0] cmd_i = 8'h00, dat_i = 8'h00;
    wire [7:0] dat_o, usb_rx_dat_i, usb_tx_dat_o;
    wire [6:0] usb_tx_len_o;
    wire [1:0] usb_tok_pid_i, usb_hs_o;
    wire dat_vld_o, ep_int_o, usb_tok_vld_i, usb_tok_ep_i, usb_rx_vld_i, usb_rx_end_i;
    wire usb_ack_i, usb_tx_rd_i, usb_hs_vld_o, usb_tx_start_o, usb_tx_data1_o;
    wire usb_rx_ok_i = usb_rx_end_i; // crc always good
    int bad_count = 0, checked = 0;
    logic [2:0] r;

    uesb_ep_core dut (.*);
    uesb_host_model host (.clk_sys_i, .hs_vld_i(usb_hs_vld_o), .hs_i(usb_hs_o),
        .tx_start_i(usb_tx_start_o), .tx_len_i(usb_tx_len_o), .tx_dat_i(usb_tx_dat_o),
        .tok_vld_o(usb_tok_vld_i), .tok_pid_o(usb_tok_pid_i), .tok_ep_o(usb_tok_ep_i),
        .rx_vld_o(usb_rx_vld_i), .rx_dat_o(usb_rx_dat_i), .rx_end_o(usb_rx_end_i),
        .tx_rd_o(usb_tx_rd_i), .ack_o(usb_ack_i));

    // 125 MHz clock
    initial forever #4 clk_sys_i = ~clk_sys_i;

    task complete_run;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task chk(input string nm, input [7:0] e, input [7:0] g);
        checked++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask

    // w low: command code, high: data byte
    task put(input w, input [7:0] b);
        @(negedge clk_sys_i);
        cmd_wr_i = !w;
        dat_wr_i = w;
        cmd_i = b;
        dat_i = b;
        @(negedge clk_sys_i);
        cmd_wr_i = 0;
        dat_wr_i = 0;
    endtask

    // read one byte, bounded wait, masked compare
    task rd(input string nm, input [7:0] m, input [7:0] e);
        int i;
        @(negedge clk_sys_i);
        dat_rd_i = 1;
        @(negedge clk_sys_i);
        dat_rd_i = 0;
        for (i = 0; i < 4 && dat_vld_o !== 1'b1; i++) @(negedge clk_sys_i);
        chk("vld", 8'h01, {7'h0, dat_vld_o});
        chk(nm, e, dat_o & m);
    endtask

    task tr(input string nm, input [1:0] p, input ep, input [7:0] n, input [2:0] e);
        host.xfer(p, ep, n, r);
        chk(nm, {5'h0, e}, {5'h0, r});
    endtask

    // load the control in buffer with one byte and validate it
    task ld(input [7:0] b);
        put(0, 8'h01);
        put(0, `UESB_CMD_BUF);
        put(1, 8'h00);
        put(1, 8'h01);
        put(1, b);
        put(0, `UESB_CMD_VAL);
    endtask

    // watchdog, far past the sequence length
    initial begin
        #100us;
        bad_count++;
        $display("[FAIL] watchdog expected end seen hang");
        complete_run;
    end

    // main sequence
    initial begin
        repeat (5) @(negedge clk_sys_i);
        rst_n_i = 1;
        for (int e = 0; e < 4; e++) begin
            put(0, e[7:0]);
            rd("sel_por", 8'hFF, 8'h00);
        end
        put(0, `UESB_CMD_CLR);
        rd("clr_por", 8'hFF, 8'h00);
        tr("out_ack", `UESB_PID_OUT, 0, 3, 3'h0);
        put(0, 8'h00);
        rd("sel_full", 8'hFF, 8'h01);
        put(0, `UESB_CMD_BUF);
        rd("hdr", 8'hFF, 8'h80);
        rd("cnt", 8'hFF, 8'h03);
        rd("d0", 8'hFF, 8'hC0);
        rd("d1", 8'hFF, 8'hC1);
        tr("out_nak", `UESB_PID_OUT, 0, 2, 3'h1);
        repeat (2) @(negedge clk_sys_i);
        chk("int", 8'h01, {7'h0, ep_int_o});
        put(0, 8'h00);
        rd("sel_nak", 8'hFF, 8'h11);
        tr("stp_ack", `UESB_PID_SETUP, 0, 8, 3'h0);
        put(0, `UESB_CMD_CLR);
        rd("clr_ovw", 8'hFF, 8'h01);
        put(0, 8'h00);
        rd("sel_ovw", 8'hFF, 8'h0D);
        put(0, `UESB_CMD_CLR);
        rd("clr_ok", 8'hFF, 8'h00);
        put(0, 8'h00);
        rd("sel_clr", 8'hFF, 8'h04);
        tr("in_nak", `UESB_PID_IN, 0, 0, 3'h1);
        ld(8'hA5);
        put(0, 8'h01);
        rd("in_full", 8'hFF, 8'h11);
        tr("in_go", `UESB_PID_IN, 0, 0, 3'h4);
        chk("in_len", 8'h01, {1'b0, host.len});
        chk("in_dat", 8'hA5, host.b0);
        put(0, 8'h01);
        rd("in_ack", 8'h10, 8'h00);
        // stall a loaded buffer, then let a setup token release it
        ld(8'h77);
        put(0, `UESB_CMD_SET_ST + 8'h01);
        put(1, 8'h01);
        tr("in_stl", `UESB_PID_IN, 0, 0, 3'h2);
        put(0, 8'h01);
        rd("sel_stl", 8'h02, 8'h02);
        tr("stp_unstl", `UESB_PID_SETUP, 0, 8, 3'h0);
        tr("in_flush", `UESB_PID_IN, 0, 0, 3'h1);
        // disable a bulk out endpoint, bus reset enables it again
        put(0, `UESB_CMD_SET_ST + 8'h02);
        put(1, 8'h20);
        tr("dis", `UESB_PID_OUT, 1, 2, 3'h3);
        usb_bus_rst_i = 1;
        @(negedge clk_sys_i);
        usb_bus_rst_i = 0;
        tr("ena", `UESB_PID_OUT, 1, 2, 3'h0);
        complete_run;
    end
endmodule // usb_endpoint_status_buffers_bench
